// >>> hw/tdpb_map.svh
// Purpose: Constants of the dual-port block memory port: widths, offsets, resets, latencies
// Assumes: Included by the package and by design files by bare name
// Notes:   Definitions only
`ifndef TDPB_MAP_SVH
`define TDPB_MAP_SVH

// ----------------------------------------------------------------
// Bus and storage geometry
// ----------------------------------------------------------------
`define TDPB_DATA_W      20
`define TDPB_ADDR_W      14
`define TDPB_MAIN_W      16
`define TDPB_EXT_W       2
`define TDPB_DEPTH       1024
`define TDPB_WORD_ABITS  10
`define TDPB_SUB_ABITS   4

// ----------------------------------------------------------------
// Field positions inside a packed 20-bit bus word {ext2, ext1, main}
// ----------------------------------------------------------------
`define TDPB_MAIN_LSB    0
`define TDPB_EXT1_LSB    16
`define TDPB_EXT2_LSB    18

// ----------------------------------------------------------------
// Reset values and read latencies in clock cycles
// ----------------------------------------------------------------
`define TDPB_INITVAL     20'h00000
`define TDPB_SRVAL       20'h00000
`define TDPB_LAT_LATCHED 1
`define TDPB_LAT_REGD    2

`endif

// >>> hw/tdpb_pkg.sv
// Purpose: Types and data-mapping functions shared by both ends of the memory port
// Assumes: tdpb_map.svh supplies the geometry macros
// Notes:   Bus words are packed as {ext2[1:0], ext1[1:0], main[15:0]}
`default_nettype none
`include "tdpb_map.svh"

package tdpb_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [`TDPB_DATA_W-1:0] tdpb_word_t;
	typedef logic [`TDPB_ADDR_W-1:0] tdpb_addr_t;
	typedef enum {TDPB_WRITE_FIRST, TDPB_NO_CHANGE} tdpb_write_mode_t;
	typedef enum {TDPB_PRI_RSTREG, TDPB_PRI_REGCE} tdpb_regce_pri_t;
	typedef enum {TDPB_RS_CLOCKED, TDPB_RS_UNCLOCKED} tdpb_reg_rst_sync_t;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Low-bit mask of a logical data word
	function automatic tdpb_word_t tdpb_mask(input int unsigned w);
		logic [`TDPB_DATA_W:0] m;
		m = (21'h000001 << w) - 21'h000001;
		return m[`TDPB_DATA_W-1:0];
	endfunction

	// Logical data to bus word; odd widths spread onto the extension buses
	function automatic tdpb_word_t tdpb_pack(input tdpb_word_t d, input int unsigned w);
		tdpb_word_t b;
		b = '0;
		case (w)
			20: b = {d[19], d[9], d[14], d[4], d[18:15], d[13:10], d[8:5], d[3:0]};
			18: b = {2'h0, d[17], d[8], d[16:9], d[7:0]};
			10: b = {1'b0, d[9], 1'b0, d[4], 8'h00, d[8:5], d[3:0]};
			9: b = {3'h0, d[8], 8'h00, d[7:0]};
			5: b = {3'h0, d[4], 12'h000, d[3:0]};
			default: b = d & tdpb_mask(w);
		endcase
		return b;
	endfunction

	// Bus word back to logical data
	function automatic tdpb_word_t tdpb_unpack(input tdpb_word_t b, input int unsigned w);
		tdpb_word_t d;
		d = '0;
		case (w)
			20: d = {b[19], b[15:12], b[17], b[11:8], b[18], b[7:4], b[16], b[3:0]};
			18: d = {2'h0, b[17], b[15:8], b[16], b[7:0]};
			10: d = {10'h000, b[18], b[7:4], b[16], b[3:0]};
			9: d = {11'h000, b[16], b[7:0]};
			5: d = {15'h0000, b[16], b[3:0]};
			default: d = b & tdpb_mask(w);
		endcase
		return d;
	endfunction

	// Number of used address bits for a given width
	function automatic int unsigned tdpb_abits(input int unsigned w);
		int unsigned n;
		n = 14;
		case (w)
			20, 18, 16: n = 10;
			10, 9, 8: n = 11;
			5, 4: n = 12;
			2: n = 13;
			default: n = 14;
		endcase
		return n;
	endfunction

	// Bit offset of a narrow element inside a 1k-deep storage word
	function automatic logic [4:0] tdpb_bit_off(input tdpb_addr_t a, input int unsigned w);
		logic [3:0]  sub;
		int unsigned prod;
		sub = a[3:0] >> (`TDPB_ADDR_W - tdpb_abits(w));
		prod = 32'(sub) * w;
		return prod[4:0];
	endfunction

endpackage

`default_nettype wire

// >>> hw/tdpb_port_if.sv
// Purpose: One memory port between user fabric logic and the block memory
// Assumes: Both ends run on the same clock
// Notes:   No clocking block; the testbench joins the ends
`timescale 1ns/1ps
`default_nettype none

interface tdpb_port_if;
	// ----------------------------------------------------------------
	// Port signals
	// ----------------------------------------------------------------
	logic [13:0] addr;
	logic [15:0] din;
	logic [1:0]  dinp;
	logic [1:0]  dinpx;
	logic        port_en;
	logic        wr_en;
	logic        rst_latch;
	logic        rst_reg;
	logic        out_reg_ce;
	logic [15:0] dout;
	logic [1:0]  doutp;
	logic [1:0]  doutpx;

	modport mem_mp (input addr, din, dinp, dinpx, port_en, wr_en, rst_latch, rst_reg,
		out_reg_ce, output dout, doutp, doutpx);
	modport user_mp (output addr, din, dinp, dinpx, port_en, wr_en, rst_latch, rst_reg,
		out_reg_ce, input dout, doutp, doutpx);
endinterface

`default_nettype wire

// >>> hw/tdpb_mem.sv
// Purpose: True dual-port block memory, both ports sharing one storage array
// Assumes: Both ports on mclk_in; user logic keeps addresses left-justified
// Notes:   Collisions between the ports give undefined data, as in the real array
//          A width set that mixes groups leaves storage untouched by writes
//
// Overview of operation
// [R1] Widths one to twenty bits per port
// [R2] Read and write widths set independently
// [R3] Widths mix only within their group
// [R4] Main bus plus two extension buses
// [R5] Twenty and eighteen bit lane mapping
// [R6] Ten, nine, five bit lanes; powers plain
// [R7] Driver left-justifies word address, zeroes rest
// [R8] Used address bits depend on depth
// [R9] Output register off gives one cycle
// [R10] Output register on gives two cycles
// [R11] Read: enable high, write enable low
// [R12] Write: enables high, stored next edge
// [R13] Write-first shows written data on outputs
// [R14] No-change holds outputs during writes
// [R15] Latch reset first, then enable, mode
// [R16] Register reset priority versus clock enable
// [R17] Latch and register start at initval
// [R18] Register reset clocked or unclocked
// [R19] Ports share storage, act independently
`timescale 1ns/1ps
`default_nettype none
`include "tdpb_map.svh"

module tdpb_mem #(
	parameter int unsigned                  RD_WIDTH [2]     = '{20, 20},
	parameter int unsigned                  WR_WIDTH [2]     = '{20, 20},
	parameter bit                           OUT_REG [2]      = '{1'b0, 1'b0},
	parameter tdpb_pkg::tdpb_write_mode_t   WRITE_MODE [2]   = '{tdpb_pkg::TDPB_WRITE_FIRST,
		tdpb_pkg::TDPB_WRITE_FIRST},
	parameter tdpb_pkg::tdpb_regce_pri_t    REGCE_PRI [2]    = '{tdpb_pkg::TDPB_PRI_RSTREG,
		tdpb_pkg::TDPB_PRI_RSTREG},
	parameter tdpb_pkg::tdpb_reg_rst_sync_t REG_RST_SYNC [2] = '{tdpb_pkg::TDPB_RS_CLOCKED,
		tdpb_pkg::TDPB_RS_CLOCKED},
	parameter logic [19:0]                  INITVAL [2]      = '{`TDPB_INITVAL, `TDPB_INITVAL},
	parameter logic [19:0]                  SRVAL [2]        = '{`TDPB_SRVAL, `TDPB_SRVAL}
) (
	input  wire logic           mclk_in,
	input  wire logic           rst_in,
	input  wire logic           clk_en_in,
	tdpb_port_if.mem_mp         port_a,
	tdpb_port_if.mem_mp         port_b
);

	// ----------------------------------------------------------------
	// Width group check
	// ----------------------------------------------------------------
	// Group of a port width: 0 for 20/10/5, 1 for 18/9, 2 for powers of two;
	// 3 marks a width that no group holds
	function automatic logic [1:0] width_group(input int unsigned w);
		logic [1:0] g;
		g = 2'h3;
		case (w)
			20, 10, 5: g = 2'h0;
			18, 9: g = 2'h1;
			16, 8, 4, 2, 1: g = 2'h2;
			default: g = 2'h3;
		endcase
		return g;
	endfunction

	// All four widths must share one group. A mixed set would slice rows
	// differently on each side, so it is refused by blocking every write:
	// storage then keeps whatever it held and no port corrupts the other
	localparam bit WIDTHS_OK = (width_group(RD_WIDTH[0]) != 2'h3)
		&& (width_group(WR_WIDTH[0]) == width_group(RD_WIDTH[0]))
		&& (width_group(RD_WIDTH[1]) == width_group(RD_WIDTH[0]))
		&& (width_group(WR_WIDTH[1]) == width_group(RD_WIDTH[0])); // R1 R3

	// ----------------------------------------------------------------
	// Storage and per-port views of the two interfaces
	// ----------------------------------------------------------------
	// One logical 20-bit word per row; narrow ports address slices of a row
	tdpb_pkg::tdpb_word_t mem [0:`TDPB_DEPTH-1];

	tdpb_pkg::tdpb_addr_t addr_s [2];
	tdpb_pkg::tdpb_word_t din_s [2];
	tdpb_pkg::tdpb_word_t dout_s [2];
	logic                 pe_s [2];
	logic                 we_s [2];
	logic                 rl_s [2];
	logic                 rr_s [2];
	logic                 ce_s [2];

	// Gather both ports into arrays so one generate serves both
	assign addr_s[0] = port_a.addr;
	assign addr_s[1] = port_b.addr;
	assign din_s[0]  = {port_a.dinpx, port_a.dinp, port_a.din}; // R4
	assign din_s[1]  = {port_b.dinpx, port_b.dinp, port_b.din}; // R4
	assign pe_s[0]   = port_a.port_en;
	assign pe_s[1]   = port_b.port_en;
	assign we_s[0]   = port_a.wr_en;
	assign we_s[1]   = port_b.wr_en;
	assign rl_s[0]   = port_a.rst_latch;
	assign rl_s[1]   = port_b.rst_latch;
	assign rr_s[0]   = port_a.rst_reg;
	assign rr_s[1]   = port_b.rst_reg;
	assign ce_s[0]   = port_a.out_reg_ce;
	assign ce_s[1]   = port_b.out_reg_ce;

	// Output buses split back out of the packed bus word
	assign port_a.dout   = dout_s[0][`TDPB_EXT1_LSB-1:`TDPB_MAIN_LSB]; // R4
	assign port_a.doutp  = dout_s[0][`TDPB_EXT2_LSB-1:`TDPB_EXT1_LSB];
	assign port_a.doutpx = dout_s[0][`TDPB_DATA_W-1:`TDPB_EXT2_LSB];
	assign port_b.dout   = dout_s[1][`TDPB_EXT1_LSB-1:`TDPB_MAIN_LSB]; // R4
	assign port_b.doutp  = dout_s[1][`TDPB_EXT2_LSB-1:`TDPB_EXT1_LSB];
	assign port_b.doutpx = dout_s[1][`TDPB_DATA_W-1:`TDPB_EXT2_LSB];

	// ----------------------------------------------------------------
	// Shared array writes
	// ----------------------------------------------------------------
	// Both ports write on the same edge; both read the old row, so a
	// same-row collision keeps port B's slice only, which is undefined anyway
	always_ff @(posedge mclk_in)
	begin
		if (clk_en_in)
		begin
			for (int p = 0; p < 2; p++)
			begin
				// Writes only land when the width set is a legal one
				if (WIDTHS_OK && pe_s[p] && we_s[p]) // R3 R12
				begin
					mem[addr_s[p][13:4]] <= (mem[addr_s[p][13:4]] // R19
						& ~(tdpb_pkg::tdpb_mask(WR_WIDTH[p])
						<< tdpb_pkg::tdpb_bit_off(addr_s[p], WR_WIDTH[p]))) // R8
						| ((tdpb_pkg::tdpb_unpack(din_s[p], WR_WIDTH[p]) // R5 R6
						& tdpb_pkg::tdpb_mask(WR_WIDTH[p]))
						<< tdpb_pkg::tdpb_bit_off(addr_s[p], WR_WIDTH[p])); // R1 R2
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-port output path
	// ----------------------------------------------------------------
	for (genvar p = 0; p < 2; p++)
	begin : g_port
		tdpb_pkg::tdpb_word_t rd_data;
		tdpb_pkg::tdpb_word_t latch_reg;
		tdpb_pkg::tdpb_word_t latch_next;
		tdpb_pkg::tdpb_word_t oreg_reg;
		logic                 oreg_arst;

		// Slice the addressed element out of its row at the read width
		always_comb
		begin
			rd_data = (mem[addr_s[p][13:4]] >> tdpb_pkg::tdpb_bit_off(addr_s[p], RD_WIDTH[p]))
				& tdpb_pkg::tdpb_mask(RD_WIDTH[p]); // R2 R8
		end

		// Latch stage priority: reset, enable, then read or write mode
		always_comb
		begin
			latch_next = latch_reg; // R15
			if (rl_s[p])
				latch_next = tdpb_pkg::tdpb_pack(SRVAL[p], RD_WIDTH[p]); // R15
			else if (!pe_s[p])
				latch_next = latch_reg; // R15
			else if (!we_s[p])
				latch_next = tdpb_pkg::tdpb_pack(rd_data, RD_WIDTH[p]); // R5 R6 R9
			else if (WRITE_MODE[p] == tdpb_pkg::TDPB_WRITE_FIRST)
				latch_next = din_s[p]; // R13
			else
				latch_next = latch_reg; // R14
		end

		// Latch stage; loads its power-up value under system reset
		always_ff @(posedge mclk_in or posedge rst_in)
		begin
			if (rst_in)
				latch_reg <= tdpb_pkg::tdpb_pack(INITVAL[p], RD_WIDTH[p]); // R17
			else if (clk_en_in)
				latch_reg <= latch_next; // R9
		end

		// Unclocked register reset bypasses the clock entirely
		assign oreg_arst = rst_in
			| ((REG_RST_SYNC[p] == tdpb_pkg::TDPB_RS_UNCLOCKED) & rr_s[p]); // R18

		// Output register; reset priority chosen per port
		always_ff @(posedge mclk_in or posedge oreg_arst)
		begin
			if (rst_in)
				oreg_reg <= tdpb_pkg::tdpb_pack(INITVAL[p], RD_WIDTH[p]); // R17
			else if (oreg_arst)
				oreg_reg <= tdpb_pkg::tdpb_pack(SRVAL[p], RD_WIDTH[p]); // R18
			else if (clk_en_in)
			begin
				if (rr_s[p] && (REGCE_PRI[p] == tdpb_pkg::TDPB_PRI_RSTREG || ce_s[p]))
					oreg_reg <= tdpb_pkg::tdpb_pack(SRVAL[p], RD_WIDTH[p]); // R16
				else if (ce_s[p])
					oreg_reg <= latch_reg; // R10 R16
			end
		end

		// Mode picks which flip-flop drives the port; fixed at elaboration
		if (OUT_REG[p])
		begin : g_regd
			assign dout_s[p] = oreg_reg; // R10
		end
		else
		begin : g_latched
			assign dout_s[p] = latch_reg; // R9
		end
	end

endmodule

`default_nettype wire

// >>> hw/tdpb_user.sv
// Purpose: User fabric end driving one block memory port
// Assumes: Same clock and clock enable as the memory
// Notes:   Valid flag ignores register clock enable; with OUT_REG set it tracks reads only while that stays high
`timescale 1ns/1ps
`default_nettype none
`include "tdpb_map.svh"

module tdpb_user #(
	parameter int unsigned WR_WIDTH = 20,
	parameter int unsigned RD_WIDTH = 20,
	parameter bit          OUT_REG  = 1'b0
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        clk_en_in,
	input  wire logic        rd_req_in,
	input  wire logic        wr_req_in,
	input  wire logic [13:0] word_addr_in,
	input  wire logic [19:0] wr_data_in,
	input  wire logic        latch_rst_in,
	input  wire logic        reg_rst_in,
	input  wire logic        reg_ce_in,
	output logic      [19:0] rd_data_out,
	output logic             rd_valid_out,
	tdpb_port_if.user_mp     bram
);

	// ----------------------------------------------------------------
	// Request registers
	// ----------------------------------------------------------------
	tdpb_pkg::tdpb_word_t bus_w;
	logic [2:0]           vld_reg;
	int unsigned          shift;

	// Write width sets the address shift on writes, read width on reads
	always_comb
	begin
		bus_w = tdpb_pkg::tdpb_pack(wr_data_in, WR_WIDTH); // R5 R6
		shift = `TDPB_ADDR_W - tdpb_pkg::tdpb_abits(wr_req_in ? WR_WIDTH : RD_WIDTH);
	end

	// Drive the port; a write wins when both requests come together
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			bram.addr       <= 14'h0000;
			bram.din        <= 16'h0000;
			bram.dinp       <= 2'h0;
			bram.dinpx      <= 2'h0;
			bram.port_en    <= 1'b0;
			bram.wr_en      <= 1'b0;
			bram.rst_latch  <= 1'b0;
			bram.rst_reg    <= 1'b0;
			bram.out_reg_ce <= 1'b0;
		end
		else if (clk_en_in)
		begin
			bram.addr       <= word_addr_in << shift; // R7 R8
			bram.din        <= bus_w[15:0]; // R12
			bram.dinp       <= bus_w[17:16];
			bram.dinpx      <= bus_w[19:18];
			bram.port_en    <= rd_req_in | wr_req_in; // R11 R12
			bram.wr_en      <= wr_req_in; // R11
			bram.rst_latch  <= latch_rst_in;
			bram.rst_reg    <= reg_rst_in;
			bram.out_reg_ce <= reg_ce_in;
		end
	end

	// ----------------------------------------------------------------
	// Read return
	// ----------------------------------------------------------------
	// Capture every cycle; valid marks the cycle a read's data lands
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			vld_reg      <= 3'h0;
			rd_valid_out <= 1'b0;
			rd_data_out  <= 20'h00000;
		end
		else if (clk_en_in)
		begin
			// Data reaches rd_data_out one edge after the port shows it,
			// so valid trails the port latency by one stage
			vld_reg      <= {vld_reg[1:0], rd_req_in & ~wr_req_in};
			rd_valid_out <= OUT_REG ? vld_reg[2] : vld_reg[1]; // R9 R10
			rd_data_out  <= tdpb_pkg::tdpb_unpack({bram.doutpx, bram.doutp, bram.dout},
				RD_WIDTH); // R5 R6
		end
	end

endmodule

`default_nettype wire

// >>> bench/tdpb_port_props.sv
// Purpose: Assertions on port A of the dual-port memory
// Assumes: Port A is 20 bits wide, latched, write-first, reset value zero
// Notes:   Takes interface signals directly; placed beside if_a
`timescale 1ns/1ps
`default_nettype none

module tdpb_port_props (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        clk_en_in,
	input  wire logic [13:0] addr_in,
	input  wire logic [15:0] din_in,
	input  wire logic [1:0]  dinp_in,
	input  wire logic [1:0]  dinpx_in,
	input  wire logic        port_en_in,
	input  wire logic        wr_en_in,
	input  wire logic        rst_latch_in,
	input  wire logic [15:0] dout_in,
	input  wire logic [1:0]  doutp_in,
	input  wire logic [1:0]  doutpx_in
);
	// ----------------------------------------------------------------
	// Whole bus words
	// ----------------------------------------------------------------
	logic [19:0] bus_q;
	logic [19:0] bus_w;

	// Extension buses sit on top, as the port packs them
	assign bus_q = {doutpx_in, doutp_in, dout_in};
	assign bus_w = {dinpx_in, dinp_in, din_in};

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	// ----------------------------------------------------------------
	// Steps and properties
	// ----------------------------------------------------------------
	sequence s_wr;
		clk_en_in && !rst_latch_in && port_en_in && wr_en_in;
	endsequence
	sequence s_rd_same;
		clk_en_in && !rst_latch_in && port_en_in && !wr_en_in && addr_in == $past(addr_in);
	endsequence
	sequence s_idle;
		clk_en_in && !rst_latch_in && !port_en_in;
	endsequence

	property p_init;
		$fell(rst_in) |-> bus_q == 20'h00000;
	endproperty
	property p_latch_rst;
		clk_en_in && rst_latch_in |=> bus_q == 20'h00000;
	endproperty
	property p_hold;
		s_idle |=> $stable(bus_q);
	endproperty
	property p_wf;
		s_wr |=> bus_q == $past(bus_w);
	endproperty
	property p_wf_stands;
		s_wr ##1 s_idle |=> bus_q == $past(bus_w, 2);
	endproperty
	property p_raw;
		s_wr ##1 s_rd_same |=> bus_q == $past(bus_w, 2);
	endproperty
	property p_freeze;
		!clk_en_in |=> $stable(bus_q);
	endproperty
	// A change needs an enabled edge with access or latch reset behind it
	property p_cause;
		!$stable(bus_q) |-> $past(clk_en_in) && ($past(port_en_in) || $past(rst_latch_in));
	endproperty

	a_init: assert property (p_init) else $error("output not at initial value");
	a_latch_rst: assert property (p_latch_rst) else $error("latch reset missed");
	a_hold: assert property (p_hold) else $error("idle port changed output");
	a_wf: assert property (p_wf) else $error("write data not shown");
	a_wf_stands: assert property (p_wf_stands) else $error("write data not held");
	a_raw: assert property (p_raw) else $error("read after write wrong");
	a_freeze: assert property (p_freeze) else $error("output moved while frozen");
	a_cause: assert property (p_cause) else $error("output changed without cause");
endmodule

`default_nettype wire

// >>> bench/test_true_dual_port_bram_port.sv
// Purpose: Self-checking bench joining two user ends to the dual-port memory
// Assumes: Port A 20-bit latched write-first; port B 10-bit registered no-change
// Notes:   Both widths share one group, so the ports see each other's rows
`timescale 1ns/1ps
`default_nettype none

module test_true_dual_port_bram_port;
	logic        mclk;
	logic        rst;
	logic        cen;
	logic        rq [2];
	logic        wq [2];
	logic [13:0] wa [2];
	logic [19:0] wd [2];
	logic        lr [2];
	logic        rr [2];
	logic        rce [2];
	logic [19:0] rdo [2];
	logic        rv [2];
	int          bad_count;
	int          n_compared;

	tdpb_port_if if_a ();
	tdpb_port_if if_b ();

	tdpb_mem #(.RD_WIDTH('{20, 10}), .WR_WIDTH('{20, 10}), .OUT_REG('{1'b0, 1'b1}),
		.WRITE_MODE('{tdpb_pkg::TDPB_WRITE_FIRST, tdpb_pkg::TDPB_NO_CHANGE})) i_tdpb_mem (
		.mclk_in(mclk), .rst_in(rst), .clk_en_in(cen), .port_a(if_a), .port_b(if_b));

	tdpb_user #(.WR_WIDTH(20), .RD_WIDTH(20), .OUT_REG(1'b0)) i_tdpb_user_a (.mclk_in(mclk),
		.rst_in(rst), .clk_en_in(cen), .rd_req_in(rq[0]), .wr_req_in(wq[0]), .word_addr_in(wa[0]),
		.wr_data_in(wd[0]), .latch_rst_in(lr[0]), .reg_rst_in(rr[0]), .reg_ce_in(rce[0]),
		.rd_data_out(rdo[0]), .rd_valid_out(rv[0]), .bram(if_a));

	tdpb_user #(.WR_WIDTH(10), .RD_WIDTH(10), .OUT_REG(1'b1)) i_tdpb_user_b (.mclk_in(mclk),
		.rst_in(rst), .clk_en_in(cen), .rd_req_in(rq[1]), .wr_req_in(wq[1]), .word_addr_in(wa[1]),
		.wr_data_in(wd[1]), .latch_rst_in(lr[1]), .reg_rst_in(rr[1]), .reg_ce_in(rce[1]),
		.rd_data_out(rdo[1]), .rd_valid_out(rv[1]), .bram(if_b));

	tdpb_port_props i_tdpb_port_props (.mclk_in(mclk), .rst_in(rst), .clk_en_in(cen),
		.addr_in(if_a.addr), .din_in(if_a.din), .dinp_in(if_a.dinp), .dinpx_in(if_a.dinpx),
		.port_en_in(if_a.port_en), .wr_en_in(if_a.wr_en), .rst_latch_in(if_a.rst_latch),
		.dout_in(if_a.dout), .doutp_in(if_a.doutp), .doutpx_in(if_a.doutpx));

	// ----------------------------------------------------------------
	// Clock and helpers
	// ----------------------------------------------------------------
	// 20 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Drives on a rising edge; the next edge takes the request
	task automatic req(input int p, input logic r, input logic w, input logic [13:0] a,
		input logic [19:0] d);
		@(posedge mclk);
		rq[p] <= r;
		wq[p] <= w;
		wa[p] <= a;
		wd[p] <= d;
	endtask

	task automatic idle(input int p);
		req(p, 1'b0, 1'b0, 14'h0000, 20'h00000);
	endtask

	// Samples at the falling edge, where outputs have settled
	task automatic look(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask

	// Read, then judge latency and data; bounded so a lost pulse cannot hang
	task automatic rd_chk(input int p, input logic [13:0] a, input logic [19:0] exp,
		input string nm);
		int n;
		n = 0;
		req(p, 1'b1, 1'b0, a, 20'h00000);
		idle(p);
		while (n < 8 && rv[p] !== 1'b1)
		begin
			@(negedge mclk);
			n++;
		end
		chk({nm, " latency"}, 20'(n), p == 0 ? 20'h00003 : 20'h00004);
		chk(nm, rdo[p], exp);
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_a_rw();
		req(0, 1'b0, 1'b1, 14'h0005, 20'habcde);
		rd_chk(0, 14'h0005, 20'habcde, "a raw");
		req(0, 1'b0, 1'b1, 14'h0006, 20'h12345);
		rd_chk(0, 14'h0006, 20'h12345, "a w6");
		rd_chk(0, 14'h0005, 20'habcde, "a w5 kept");
	endtask

	// Latch reset wins over a read but leaves storage alone
	task automatic t_a_lrst();
		@(posedge mclk);
		lr[0] <= 1'b1;
		rd_chk(0, 14'h0005, 20'h00000, "a rd rst");
		@(posedge mclk);
		lr[0] <= 1'b0;
		rd_chk(0, 14'h0005, 20'habcde, "a after rst");
	endtask

	// Narrow port B and wide port A share rows
	task automatic t_b_share();
		req(1, 1'b0, 1'b1, 14'h000a, 20'h002a5);
		req(1, 1'b0, 1'b1, 14'h000b, 20'h0015a);
		idle(1);
		rd_chk(0, 14'h0005, 20'h56aa5, "a sees b");
		rd_chk(1, 14'h000a, 20'h002a5, "b lo");
		req(0, 1'b0, 1'b1, 14'h0007, 20'h9c3b7);
		idle(0);
		look(2);
		chk("a wr first", rdo[0], 20'h9c3b7);
		rd_chk(1, 14'h000e, 20'h003b7, "b e14");
		rd_chk(1, 14'h000f, 20'h00270, "b e15");
	endtask

	task automatic t_b_nc_reg();
		req(1, 1'b0, 1'b1, 14'h0010, 20'h00111);
		idle(1);
		look(3);
		chk("b no change", rdo[1], 20'h00270);
		rd_chk(1, 14'h0010, 20'h00111, "b e16");
		@(posedge mclk);
		rce[1] <= 1'b0;
		req(1, 1'b1, 1'b0, 14'h000a, 20'h00000);
		idle(1);
		look(5);
		chk("b ce hold", rdo[1], 20'h00111);
		@(posedge mclk);
		rr[1] <= 1'b1;
		look(3);
		chk("b reg rst", rdo[1], 20'h00000);
		@(posedge mclk);
		rr[1] <= 1'b0;
		rce[1] <= 1'b1;
		look(3);
		chk("b ce load", rdo[1], 20'h002a5);
		@(posedge mclk);
		lr[1] <= 1'b1;
		rd_chk(1, 14'h000a, 20'h00000, "b rd rst");
		@(posedge mclk);
		lr[1] <= 1'b0;
	endtask

	// Output register controls must not reach a latched port
	task automatic t_a_regctl();
		@(posedge mclk);
		rr[0] <= 1'b1;
		rce[0] <= 1'b0;
		rd_chk(0, 14'h0006, 20'h12345, "a reg ctl");
		@(posedge mclk);
		rr[0] <= 1'b0;
		rce[0] <= 1'b1;
	endtask

	// A write offered while the clock enable is low must leave no trace
	task automatic t_freeze();
		@(posedge mclk);
		cen <= 1'b0;
		req(0, 1'b0, 1'b1, 14'h0005, 20'hfffff);
		idle(0);
		look(2);
		chk("frozen out", rdo[0], 20'h9c3b7);
		@(posedge mclk);
		cen <= 1'b1;
		rd_chk(0, 14'h0005, 20'h56aa5, "frozen mem");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		bad_count = 0;
		n_compared = 0;
		rst = 1'b1;
		cen = 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			rq[p] = 1'b0;
			wq[p] = 1'b0;
			wa[p] = 14'h0000;
			wd[p] = 20'h00000;
			lr[p] = 1'b0;
			rr[p] = 1'b0;
			rce[p] = 1'b1;
		end
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		look(1);
		chk("a init", rdo[0], 20'h00000);
		chk("b init", rdo[1], 20'h00000);
		t_a_rw();
		t_a_lrst();
		t_a_regctl();
		t_b_share();
		t_b_nc_reg();
		t_freeze();
		wrap_up();
	end

	// Whole run needs about a hundred cycles
	initial
	begin
		repeat (3000) @(posedge mclk);
		bad_count++;
		wrap_up();
	end
endmodule

`default_nettype wire
